/* rtl/csr_pkg.sv */
package csr_pkg;

  // Register map
  localparam int unsigned                ADDR_W          = 10;
  localparam int unsigned                DATA_W          = 8;
  localparam logic [ADDR_W-1:0]          PLL_POWER_ADDR  = 10'h010;
  localparam logic [ADDR_W-1:0]          PRESCALE_ADDR   = 10'h1e0;
  localparam logic [ADDR_W-1:0]          SOURCE_ADDR     = 10'h1e1;

  // Field positions
  localparam int unsigned                PWR_LSB         = 0;
  localparam int unsigned                PWR_MSB         = 1;
  localparam int unsigned                POL_BIT         = 7;
  localparam int unsigned                RATIO_LSB       = 0;
  localparam int unsigned                RATIO_MSB       = 2;
  localparam int unsigned                BYPASS_BIT      = 0;
  localparam int unsigned                SRC_SEL_BIT     = 1;

  // Field encodings
  localparam logic [1:0]                 PWR_NORMAL      = 2'h0;
  localparam logic [1:0]                 PWR_ASYNC_DOWN  = 2'h1;
  localparam logic                       SRC_EXTERNAL    = 1'h0;
  localparam logic                       SRC_OSCILLATOR  = 1'h1;
  localparam logic                       POL_POSITIVE    = 1'h0;

  // Values after reset
  localparam logic [1:0]                 PWR_RESET       = PWR_ASYNC_DOWN;
  localparam logic                       POL_RESET       = POL_POSITIVE;
  localparam logic [2:0]                 RATIO_RESET     = 3'h0;
  localparam logic                       BYPASS_RESET    = 1'h0;
  localparam logic                       SRC_SEL_RESET   = SRC_EXTERNAL;

  // Divide ratio codes, 000b is divide by 2
  localparam logic [2:0]                 RATIO_CODE_DIV2 = 3'h0;
  localparam logic [2:0]                 RATIO_CODE_DIV3 = 3'h1;
  localparam logic [2:0]                 RATIO_CODE_DIV4 = 3'h2;
  localparam logic [2:0]                 RATIO_CODE_DIV5 = 3'h3;
  localparam logic [2:0]                 RATIO_CODE_DIV6 = 3'h4;
  localparam logic [2:0]                 DIV_1           = 3'h1;
  localparam logic [2:0]                 DIV_2           = 3'h2;
  localparam logic [2:0]                 DIV_3           = 3'h3;
  localparam logic [2:0]                 DIV_4           = 3'h4;
  localparam logic [2:0]                 DIV_5           = 3'h5;
  localparam logic [2:0]                 DIV_6           = 3'h6;

  // Divider, synchroniser and read data reset values
  localparam logic [2:0]                 COUNT_RESET     = 3'h0;
  localparam logic                       OUT_RESET       = 1'h0;
  localparam logic                       SYNC_RESET      = 1'h0;
  localparam logic [7:0]                 RDATA_RESET     = 8'h00;

  // Divider phase states
  typedef enum logic {CSR_DIV_HIGH, CSR_DIV_LOW} csr_div_phase_type;

endpackage

/* rtl/csr_prescaler.sv */
`timescale 1ns/1ns
module csr_clock_route (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_ext_clk,
  input  wire logic       i_osc_clk,
  output logic            o_dist_clk,
  output logic [7:0]      o_rdata,
  output logic            o_pll_enable,
  output logic            o_pol_negative,
  output logic            o_osc_enable,
  output logic            o_prescale_used
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  logic [1:0]             pwr;
  logic [1:0]             next_pwr;
  logic                   pol;
  logic                   next_pol;
  logic [2:0]             ratio;
  logic [2:0]             next_ratio;
  logic                   bypass;
  logic                   next_bypass;
  logic                   src_sel;
  logic                   next_src_sel;
  logic [7:0]             next_rdata;

  // Source pins, two stages each
  logic                   ext_s1;
  logic                   ext_s2;
  logic                   osc_s1;
  logic                   osc_s2;
  logic                   src_prev;
  logic                   sel_level;
  logic                   src_rise;

  // Divider hookup and output stage
  logic [2:0]             divide;
  logic                   presc_clk;
  logic                   next_dist_clk;
  logic                   next_pll_enable;
  logic                   next_pol_negative;
  logic                   next_osc_enable;
  logic                   next_prescale_used;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register writes and reads, one access per strobe
  always_comb begin
    next_pwr     = pwr;
    next_pol     = pol;
    next_ratio   = ratio;
    next_bypass  = bypass;
    next_src_sel = src_sel;
    next_rdata   = o_rdata;
    if (i_wr_en) begin
      case (i_addr)
        csr_pkg::PLL_POWER_ADDR: begin
          next_pwr = i_wdata[csr_pkg::PWR_MSB:csr_pkg::PWR_LSB];
          next_pol = i_wdata[csr_pkg::POL_BIT];
        end
        csr_pkg::PRESCALE_ADDR: begin
          next_ratio = i_wdata[csr_pkg::RATIO_MSB:csr_pkg::RATIO_LSB];
        end
        csr_pkg::SOURCE_ADDR: begin
          next_bypass  = i_wdata[csr_pkg::BYPASS_BIT];
          next_src_sel = i_wdata[csr_pkg::SRC_SEL_BIT];
        end
        default: begin
        end
      endcase
    end
    if (i_rd_en) begin
      case (i_addr)
        csr_pkg::PLL_POWER_ADDR: begin
          next_rdata = {pol, 5'h00, pwr};
        end
        csr_pkg::PRESCALE_ADDR: begin
          next_rdata = {5'h00, ratio};
        end
        csr_pkg::SOURCE_ADDR: begin
          next_rdata = {6'h00, src_sel, bypass};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Field storage, defaults leave the PLL off and the divider in path
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr     <= csr_pkg::PWR_RESET;
      pol     <= csr_pkg::POL_RESET;
      ratio   <= csr_pkg::RATIO_RESET;
      bypass  <= csr_pkg::BYPASS_RESET;
      src_sel <= csr_pkg::SRC_SEL_RESET;
      o_rdata <= csr_pkg::RDATA_RESET;
    end else begin
      pwr     <= next_pwr;
      pol     <= next_pol;
      ratio   <= next_ratio;
      bypass  <= next_bypass;
      src_sel <= next_src_sel;
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds logic to contain metastability
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_s1   <= csr_pkg::SYNC_RESET;
      ext_s2   <= csr_pkg::SYNC_RESET;
      osc_s1   <= csr_pkg::SYNC_RESET;
      osc_s2   <= csr_pkg::SYNC_RESET;
      src_prev <= csr_pkg::SYNC_RESET;
    end else begin
      ext_s1   <= i_ext_clk;
      ext_s2   <= ext_s1;
      osc_s1   <= i_osc_clk;
      osc_s2   <= osc_s1;
      src_prev <= sel_level;
    end
  end

  // Source choice; a switch may give one short pulse, a known limitation
  assign sel_level = (src_sel == csr_pkg::SRC_OSCILLATOR) ? osc_s2 : ext_s2;
  assign src_rise  = sel_level & ~src_prev;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Ratio code to divide count; unused codes give divide by 1
  always_comb begin
    divide = csr_pkg::DIV_1;
    case (ratio)
      csr_pkg::RATIO_CODE_DIV2: begin
        divide = csr_pkg::DIV_2;
      end
      csr_pkg::RATIO_CODE_DIV3: begin
        divide = csr_pkg::DIV_3;
      end
      csr_pkg::RATIO_CODE_DIV4: begin
        divide = csr_pkg::DIV_4;
      end
      csr_pkg::RATIO_CODE_DIV5: begin
        divide = csr_pkg::DIV_5;
      end
      csr_pkg::RATIO_CODE_DIV6: begin
        divide = csr_pkg::DIV_6;
      end
      default: begin
        divide = csr_pkg::DIV_1;
      end
    endcase
  end

  // Divider or bypass path
  csr_prescaler csr_prescaler_inst (
    .i_clock     (i_clock),
    .i_arst_n    (i_arst_n),
    .i_src_level (sel_level),
    .i_src_rise  (src_rise),
    .i_divide    (divide),
    .i_bypass    (bypass),
    .o_clk       (presc_clk)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Output stage, all outputs leave from flip-flops
  always_comb begin
    next_dist_clk      = presc_clk;
    next_pll_enable    = (pwr == csr_pkg::PWR_NORMAL);
    next_pol_negative  = pol;
    next_osc_enable    = (src_sel == csr_pkg::SRC_OSCILLATOR);
    next_prescale_used = ~bypass;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dist_clk      <= csr_pkg::OUT_RESET;
      o_pll_enable    <= (csr_pkg::PWR_RESET == csr_pkg::PWR_NORMAL);
      o_pol_negative  <= csr_pkg::POL_RESET;
      o_osc_enable    <= (csr_pkg::SRC_SEL_RESET == csr_pkg::SRC_OSCILLATOR);
      o_prescale_used <= ~csr_pkg::BYPASS_RESET;
    end else begin
      o_dist_clk      <= next_dist_clk;
      o_pll_enable    <= next_pll_enable;
      o_pol_negative  <= next_pol_negative;
      o_osc_enable    <= next_osc_enable;
      o_prescale_used <= next_prescale_used;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////////////////////
// Integer prescaler, passes the source level through when bypassed
module csr_prescaler (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_src_level,
  input  wire logic       i_src_rise,
  input  wire logic [2:0] i_divide,
  input  wire logic       i_bypass,
  output logic            o_clk
);

  logic [2:0]                   count;
  logic [2:0]                   next_count;
  logic                         out_q;
  logic                         next_out_q;
  logic [2:0]                   last;
  logic [2:0]                   half;

  // Count source rises; the wrap test uses >= so a lowered ratio cannot overrun
  always_comb begin
    last       = 3'(i_divide - 3'h1);
    half       = 3'((4'(i_divide) + 4'h1) >> 1);
    next_count = count;
    next_out_q = out_q;
    if (i_src_rise) begin
      if (count >= last) begin
        next_count = 3'h0;
      end else begin
        next_count = 3'(count + 3'h1);
      end
      next_out_q = (next_count < half);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= csr_pkg::COUNT_RESET;
      out_q <= csr_pkg::OUT_RESET;
    end else begin
      count <= next_count;
      out_q <= next_out_q;
    end
  end

  // Divide by one shares the plain path with the bypass
  assign o_clk = (i_bypass || (i_divide == csr_pkg::DIV_1)) ? i_src_level : out_q;

endmodule

/* tb/csr_prescaler_sva.sv */
`timescale 1ns/1ns
module csr_clock_route_sva (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_ext_clk,
  input  wire logic       i_osc_clk,
  input  wire logic       o_dist_clk,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_pll_enable,
  input  wire logic       o_pol_negative,
  input  wire logic       o_osc_enable,
  input  wire logic       o_prescale_used
);
  chk_bypass_level: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_wr_en && i_addr == csr_pkg::SOURCE_ADDR |->
      ##2 o_prescale_used == !$past(i_wdata[0], 2)) else $error("bypass select");
  chk_pll_on_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_wr_en && i_addr == csr_pkg::PLL_POWER_ADDR && i_wdata[1:0] == 2'h0 |->
      ##2 o_pll_enable) else $error("pll not on");
  chk_pll_off_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_wr_en && i_addr == csr_pkg::PLL_POWER_ADDR && i_wdata[1:0] == 2'h1 |->
      ##2 !o_pll_enable) else $error("pll not off");
  chk_polarity_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_wr_en && i_addr == csr_pkg::PLL_POWER_ADDR |->
      ##2 o_pol_negative == $past(i_wdata[7], 2)) else $error("polarity");
  chk_osc_power_sel: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_wr_en && i_addr == csr_pkg::SOURCE_ADDR |->
      ##2 o_osc_enable == $past(i_wdata[1], 2)) else $error("oscillator power");
  chk_reset_defaults: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> !o_pll_enable && !o_osc_enable && o_prescale_used && !o_pol_negative)
    else $error("reset defaults");
endmodule
bind csr_clock_route csr_clock_route_sva csr_clock_route_sva_inst (.*);

/* tb/clock_source_routing_config_bench.sv */
`timescale 1ns/1ns
module clock_source_routing_config_bench;
  logic       clock     = 1'h0;
  logic       arst_n    = 1'h0;
  logic       wr_en     = 1'h0;
  logic       rd_en     = 1'h0;
  logic [9:0] addr      = 10'h000;
  logic [7:0] wdata     = 8'h00;
  logic       ext_clk   = 1'h0;
  logic       osc_clk   = 1'h0;
  logic [1:0] osc_div   = 2'h0;
  logic       dist_clk;
  logic [7:0] rdata;
  logic       pll_enable;
  logic       pol_negative;
  logic       osc_enable;
  logic       prescale_used;
  logic [7:0] rd;
  int         error_cnt  = 0;
  int         n_compared = 0;
  int         ext_rises  = 0;
  int         cycles     = 0;
  int         rises;
  int         clks;

  csr_clock_route csr_clock_route_inst (
    .i_clock         (clock),
    .i_arst_n        (arst_n),
    .i_wr_en         (wr_en),
    .i_rd_en         (rd_en),
    .i_addr          (addr),
    .i_wdata         (wdata),
    .i_ext_clk       (ext_clk),
    .i_osc_clk       (osc_clk),
    .o_dist_clk      (dist_clk),
    .o_rdata         (rdata),
    .o_pll_enable    (pll_enable),
    .o_pol_negative  (pol_negative),
    .o_osc_enable    (osc_enable),
    .o_prescale_used (prescale_used)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  // External source period 2 cycles, oscillator period 4 cycles
  always @(posedge clock) begin
    ext_clk <= ~ext_clk;
    osc_div <= osc_div + 2'h1;
    osc_clk <= osc_div[1];
    cycles  <= cycles + 1;
    if (!ext_clk) begin
      ext_rises <= ext_rises + 1;
    end
  end

  task summarize;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task cmp_reg(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task cmp_count(input string s, input int e, input int g);
    n_compared++;
    if (g != e) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", s, e, g);
    end
  endtask

  // Strobe stands for one edge, outputs settle one edge later
  task write_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task read_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'h1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'h0;
    @(negedge clock);
    d = rdata;
  endtask

  // External source rises and clock cycles within one distribution period
  task dist_span(output int r, output int n);
    int r0;
    int c0;
    @(posedge dist_clk);
    @(negedge clock);
    r0 = ext_rises;
    c0 = cycles;
    @(posedge dist_clk);
    @(negedge clock);
    r = ext_rises - r0;
    n = cycles - c0;
  endtask

  task check_defaults;
    read_reg(csr_pkg::PLL_POWER_ADDR, rd);
    cmp_reg("pll_reg", 8'h01, rd);
    read_reg(csr_pkg::PRESCALE_ADDR, rd);
    cmp_reg("ratio_reg", 8'h00, rd);
    read_reg(csr_pkg::SOURCE_ADDR, rd);
    cmp_reg("source_reg", 8'h00, rd);
    cmp_reg("pll_enable", 8'h00, {7'h00, pll_enable});
    cmp_reg("osc_enable", 8'h00, {7'h00, osc_enable});
    cmp_reg("prescale_used", 8'h01, {7'h00, prescale_used});
  endtask

  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'h1;
    repeat (2) @(posedge clock);
    check_defaults;
    repeat (20) @(posedge clock);
    dist_span(rises, clks);
    cmp_count("div_default", 2, rises);
    for (int n = 0; n < 5; n++) begin
      write_reg(csr_pkg::PRESCALE_ADDR, 8'(n));
      repeat (30) @(posedge clock);
      dist_span(rises, clks);
      cmp_count("ratio", n + 2, rises);
    end
    write_reg(csr_pkg::PRESCALE_ADDR, 8'h07);
    repeat (30) @(posedge clock);
    dist_span(rises, clks);
    cmp_count("ratio_one", 1, rises);
    write_reg(csr_pkg::SOURCE_ADDR, 8'h01);
    read_reg(csr_pkg::SOURCE_ADDR, rd);
    cmp_reg("source_reg", 8'h01, rd);
    cmp_reg("prescale_used", 8'h00, {7'h00, prescale_used});
    repeat (10) @(posedge clock);
    dist_span(rises, clks);
    cmp_count("bypass_ext", 2, clks);
    write_reg(csr_pkg::SOURCE_ADDR, 8'h03);
    cmp_reg("osc_enable", 8'h01, {7'h00, osc_enable});
    repeat (10) @(posedge clock);
    dist_span(rises, clks);
    cmp_count("bypass_osc", 4, clks);
    write_reg(csr_pkg::SOURCE_ADDR, 8'h02);
    write_reg(csr_pkg::PRESCALE_ADDR, 8'h00);
    repeat (20) @(posedge clock);
    dist_span(rises, clks);
    cmp_count("divided_osc", 8, clks);
    write_reg(csr_pkg::SOURCE_ADDR, 8'h00);
    cmp_reg("osc_enable", 8'h00, {7'h00, osc_enable});
    write_reg(csr_pkg::PLL_POWER_ADDR, 8'h00);
    cmp_reg("pll_enable", 8'h01, {7'h00, pll_enable});
    cmp_reg("pol_negative", 8'h00, {7'h00, pol_negative});
    write_reg(csr_pkg::PLL_POWER_ADDR, 8'h81);
    cmp_reg("pll_enable", 8'h00, {7'h00, pll_enable});
    cmp_reg("pol_negative", 8'h01, {7'h00, pol_negative});
    read_reg(csr_pkg::PLL_POWER_ADDR, rd);
    cmp_reg("pll_reg", 8'h81, rd);
    write_reg(csr_pkg::SOURCE_ADDR, 8'h03);
    @(posedge clock);
    arst_n <= 1'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'h1;
    repeat (2) @(posedge clock);
    check_defaults;
    summarize;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize;
  end
endmodule
